/* File: src/ebu_pkg.sv */
// Notes on behaviour
// - stream get with check flags mismatch
// - peripheral port errors raise bus faults
// - icache port errors count only uncached
// - instruction memory ecc faults
// - illegal major opcode in top six bits
// - optional all-zero instruction word is illegal
// - dcache port errors only uncached or exclusive
// - data memory ecc faults
// - unaligned word, halfword, long access
// - divide by zero or signed overflow
// - float result and operand faults
// - privileged instruction in user mode
// - r1 based access outside stack bounds
// - mmu storage violations and tlb misses
// - nested bus or opcode fault halts core
// - precise flush unless imprecise ecc option
// - delay slot, return address, jump base+0x20
// - hardware break jumps base+0x18, sets flag
// - maskable break gated, nonmaskable always taken
// - return from break clears break flag
// - trap to 0x18 signals debugger only
// - fixed priority among coinciding faults
// - return from exception restores mode flags
package ebu_pkg;
    // register byte offsets
    localparam logic [7:0] ADR_MST = 8'h00;
    localparam logic [7:0] ADR_CAU = 8'h04;
    localparam logic [7:0] ADR_FAD = 8'h08;
    localparam logic [7:0] ADR_FLT = 8'h0c;
    localparam logic [7:0] ADR_BTG = 8'h10;
    localparam logic [7:0] ADR_SLO = 8'h14;
    localparam logic [7:0] ADR_SHI = 8'h18;
    // machine status bit positions
    localparam int MB_BRK = 3;
    localparam int MB_ICO = 5;
    localparam int MB_DCO = 7;
    localparam int MB_XEN = 8;
    localparam int MB_XPR = 9;
    localparam int MB_USR = 11;
    localparam int MB_USV = 12;
    localparam int MB_VRT = 13;
    localparam int MB_VSV = 14;
    localparam logic [31:0] MST_RST = 32'h0000_0000;
    // exception status layout
    localparam int ES_DLY = 12;
    // vectors and return registers
    localparam logic [31:0] VEC_BRK = 32'h0000_0018;
    localparam logic [31:0] VEC_EXC = 32'h0000_0020;
    localparam logic [31:0] PC_STEP = 32'h0000_0004;
    localparam logic [31:0] PC_STEP2 = 32'h0000_0008;
    localparam logic [4:0] RF_BRK = 5'h10;
    localparam logic [4:0] RF_EXC = 5'h11;
    // divide overflow operands
    localparam logic [31:0] DIV_MOST_NEG = 32'h8000_0000;
    localparam logic [31:0] DIV_MINUS_ONE = 32'hffff_ffff;
    // access sizes
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_HALF = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;
    localparam logic [1:0] SZ_LONG = 2'h3;
    // cause index, highest priority first
    localparam int NCAUSE = 12;
    localparam int CI_IBUS = 0;
    localparam int CI_ITLB = 1;
    localparam int CI_ISTO = 2;
    localparam int CI_ILL = 3;
    localparam int CI_PRIV = 4;
    localparam int CI_DTLB = 5;
    localparam int CI_DSTO = 6;
    localparam int CI_UNAL = 7;
    localparam int CI_DBUS = 8;
    localparam int CI_DIV = 9;
    localparam int CI_FPU = 10;
    localparam int CI_STRM = 11;
    // cause code per index
    localparam logic [4:0] CAUSE_CODE [NCAUSE] = '{5'h03, 5'h13, 5'h11, 5'h02,
        5'h07, 5'h12, 5'h10, 5'h01, 5'h04, 5'h05, 5'h06, 5'h00};
    typedef enum logic {ST_RUN = 1'b0, ST_HALT = 1'b1} ebu_state_t;
    // execute stage view
    typedef struct packed {
        logic valid;
        logic [31:0] insn;
        logic [31:0] pc;
        logic in_delay;
        logic imm_prefix;
        logic branch_imm;
        logic [31:0] branch_target;
        logic priv_insn;
        logic ret_exc;
        logic ret_brk;
        logic trap_imm;
        logic [31:0] trap_target;
    } ebu_exe_t;
    // data access in flight
    typedef struct packed {
        logic valid;
        logic store;
        logic [1:0] size;
        logic [31:0] addr;
        logic base_r1;
        logic excl;
    } ebu_mem_t;
    // bus and local memory responses
    typedef struct packed {
        logic ip_rerr;
        logic ic_rerr;
        logic ic_inhibit;
        logic dp_err;
        logic dc_err;
        logic dc_excl_okay;
        logic dc_inhibit;
        logic imem_ue;
        logic imem_ce;
        logic dmem_ue;
        logic dmem_ce;
    } ebu_rsp_t;
    // unit and mmu checks
    typedef struct packed {
        logic div_valid;
        logic div_signed;
        logic [31:0] dividend;
        logic [31:0] divisor;
        logic fpu_valid;
        logic res_denorm;
        logic res_nan;
        logic fdiv;
        logic a_zero;
        logic b_inf;
        logic bad_operand;
        logic get_check;
        logic ctrl_mismatch;
        logic itlb_miss;
        logic istore_viol;
        logic dtlb_miss;
        logic dstore_viol;
    } ebu_unit_t;
endpackage

/* File: src/ebu_core.sv */
// Design decisions made here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
module ebu_core
    import ebu_pkg::*;
#(
    parameter logic [31:0] VEC_BASE = 32'h0000_0000,
    parameter logic [63:0] MAJOR_VALID = 64'hffff_ffff_ffff_ffff,
    parameter bit ZERO_ILLEGAL = 1'b0,
    parameter bit IC_ALWAYS = 1'b0,
    parameter bit DC_ALWAYS = 1'b0,
    parameter bit CE_TRAP = 1'b0,
    parameter bit CORE64 = 1'b0,
    parameter bit MMU_PRESENT = 1'b1,
    parameter bit FAULT_TOL = 1'b0,
    parameter bit IMPRECISE = 1'b0,
    parameter int DEBUG_LEVEL = 1
)(
    input wire logic MCLK,
    input wire logic RST_N,
    // wishbone register slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // pipeline inputs
    input wire ebu_exe_t EXE,
    input wire ebu_mem_t MEM,
    input wire ebu_rsp_t RSP,
    input wire ebu_unit_t UNIT,
    input wire logic [31:0] DEC_PC,
    input wire logic MASKABLE_BREAK_IN,
    input wire logic NONMASKABLE_BREAK_IN,
    // pipeline outputs
    output logic VECTOR_TAKE,
    output logic [31:0] VECTOR_PC,
    output logic FLUSH,
    output logic KEEP_MEM,
    output logic RF_WE,
    output logic [4:0] RF_ADDR,
    output logic [31:0] RF_DATA,
    output logic RESV_CLEAR,
    output logic SW_BREAK,
    output logic HALT_ERROR_OUT,
    output logic [31:0] STATUS
);

    logic [31:0] machine_status_reg; // machine status
    logic [31:0] exception_status_reg; // cause code, detail, delay slot
    logic [31:0] fault_address_reg; // faulting address
    logic [31:0] float_status_reg; // sticky float flags
    logic [31:0] branch_target_reg; // delay slot resume target
    logic [31:0] stack_low_reg; // stack lower bound
    logic [31:0] stack_high_reg; // stack upper bound
    logic nm_pend_reg; // pending nonmaskable break
    ebu_state_t state_reg; // run or halted
    logic [NCAUSE-1:0] cause_vec; // raw causes
    logic [3:0] sel_idx; // winning cause
    logic any_cause; // some cause this cycle
    logic exc_enter; // vector to exception handler
    logic ft_halt; // nested fault halts instead
    logic brk_take; // hardware break accepted
    logic nm_seen; // nonmaskable pending or arriving
    logic wr_hit; // register write strobe
    logic dbg_trap; // debugger breakpoint trap
    logic mmu_cause; // winner is an mmu cause
    logic data_cause; // winner names a data address
    logic ecc_cause; // winner came from local memory ecc
    logic ibus_ecc; // instruction memory ecc fault
    logic dbus_ecc; // data memory ecc fault
    logic [31:0] r17_val; // return address for handler
    logic r17_we; // return address is defined
    logic [31:0] ms_q; // alias of machine status

    assign ms_q = machine_status_reg;
    assign STATUS = machine_status_reg;

    // byte lane merge
    function automatic logic [31:0] lane_merge(input logic [31:0] old,
        input logic [31:0] din, input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
                res[8*b +: 8] = din[8*b +: 8];
        end
        return res;
    endfunction

    // write lands at the ack edge
    assign wr_hit = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O;

    // local memory ecc faults
    assign ibus_ecc = RSP.imem_ue || (CE_TRAP && RSP.imem_ce);
    assign dbus_ecc = MEM.valid && (!MEM.store || MEM.size == SZ_BYTE
        || MEM.size == SZ_HALF) && (RSP.dmem_ue || (CE_TRAP && RSP.dmem_ce));

    // raw cause detection
    always_comb
    begin
        cause_vec = '0;
        // instruction side bus faults
        cause_vec[CI_IBUS] = RSP.ip_rerr || ibus_ecc
            || (RSP.ic_rerr && ((IC_ALWAYS && !ms_q[MB_ICO]) || RSP.ic_inhibit));
        cause_vec[CI_ITLB] = MMU_PRESENT && ms_q[MB_VRT] && UNIT.itlb_miss;
        cause_vec[CI_ISTO] = MMU_PRESENT && UNIT.istore_viol;
        // major opcode: six most significant bits
        cause_vec[CI_ILL] = EXE.valid && (!MAJOR_VALID[EXE.insn[31:26]]
            || (ZERO_ILLEGAL && EXE.insn == '0));
        cause_vec[CI_PRIV] = (EXE.valid && EXE.priv_insn && ms_q[MB_USR])
            || (MEM.valid && MEM.base_r1 && (MEM.addr < stack_low_reg
            || MEM.addr > stack_high_reg));
        cause_vec[CI_DTLB] = MMU_PRESENT && ms_q[MB_VRT] && UNIT.dtlb_miss;
        cause_vec[CI_DSTO] = MMU_PRESENT && UNIT.dstore_viol;
        // alignment by access size
        cause_vec[CI_UNAL] = MEM.valid && (((MEM.size == SZ_WORD) && (|MEM.addr[1:0]))
            || ((MEM.size == SZ_HALF) && MEM.addr[0])
            || (CORE64 && (MEM.size == SZ_LONG) && (|MEM.addr[2:0])));
        cause_vec[CI_DBUS] = RSP.dp_err || dbus_ecc
            || ((RSP.dc_err || RSP.dc_excl_okay) && ((DC_ALWAYS && !ms_q[MB_DCO])
            || MEM.excl || RSP.dc_inhibit));
        cause_vec[CI_DIV] = UNIT.div_valid && (UNIT.divisor == '0
            || (UNIT.div_signed && UNIT.dividend == DIV_MOST_NEG
            && UNIT.divisor == DIV_MINUS_ONE));
        cause_vec[CI_FPU] = UNIT.fpu_valid && (UNIT.res_denorm || UNIT.res_nan
            || (UNIT.fdiv && UNIT.a_zero && !UNIT.b_inf) || UNIT.bad_operand);
        cause_vec[CI_STRM] = UNIT.get_check && UNIT.ctrl_mismatch;
    end

    // fixed priority, lowest index wins
    always_comb
    begin
        sel_idx = '0;
        for (int i = NCAUSE - 1; i >= 0; i--)
        begin
            if (cause_vec[i])
                sel_idx = 4'(i);
        end
    end

    assign any_cause = (|cause_vec) && (state_reg == ST_RUN);
    // nested bus or opcode fault while handler busy
    assign ft_halt = FAULT_TOL && ms_q[MB_XPR] && !ms_q[MB_XEN]
        && (sel_idx == 4'(CI_IBUS) || sel_idx == 4'(CI_ILL)
        || sel_idx == 4'(CI_DBUS));
    assign exc_enter = any_cause && !ft_halt;
    // breaks yield to exceptions; nonmaskable waits
    assign nm_seen = NONMASKABLE_BREAK_IN || nm_pend_reg;
    assign brk_take = (state_reg == ST_RUN) && !any_cause && (nm_seen
        || (MASKABLE_BREAK_IN && !ms_q[MB_BRK] && !ms_q[MB_XPR]));
    assign dbg_trap = (DEBUG_LEVEL > 0) && EXE.valid && EXE.trap_imm
        && EXE.trap_target == VEC_BRK && !any_cause && !brk_take;
    assign mmu_cause = sel_idx == 4'(CI_ITLB) || sel_idx == 4'(CI_ISTO)
        || sel_idx == 4'(CI_DTLB) || sel_idx == 4'(CI_DSTO);
    assign data_cause = sel_idx == 4'(CI_DTLB) || sel_idx == 4'(CI_DSTO)
        || sel_idx == 4'(CI_UNAL) || sel_idx == 4'(CI_DBUS)
        || sel_idx == 4'(CI_PRIV);
    assign ecc_cause = (sel_idx == 4'(CI_IBUS) && ibus_ecc)
        || (sel_idx == 4'(CI_DBUS) && dbus_ecc);

    // handler return address
    always_comb
    begin
        r17_we = 1'b1;
        if (EXE.in_delay)
        begin
            if (mmu_cause)
                r17_val = EXE.branch_imm ? EXE.pc - PC_STEP2 : EXE.pc - PC_STEP;
            else
            begin
                r17_val = '0; // left undefined, not written
                r17_we = 1'b0;
            end
        end
        else if (mmu_cause)
            r17_val = EXE.imm_prefix ? EXE.pc - PC_STEP : EXE.pc;
        else
            r17_val = EXE.pc + PC_STEP;
    end

    // run or halted state
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
            state_reg <= ST_RUN;
        else
        begin
            case (state_reg)
                ST_RUN:
                    if (any_cause && ft_halt)
                        state_reg <= ST_HALT;
                ST_HALT:
                    state_reg <= ST_HALT; // only reset leaves
                default:
                    state_reg <= ST_RUN;
            endcase
        end
    end

    // sticky halt error pin
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
            HALT_ERROR_OUT <= 1'b0;
        else if (any_cause && ft_halt)
            HALT_ERROR_OUT <= 1'b1;
    end

    // pending nonmaskable break, take beats arrival
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
            nm_pend_reg <= 1'b0;
        else if (NONMASKABLE_BREAK_IN && !brk_take)
            nm_pend_reg <= 1'b1;
        else if (brk_take)
            nm_pend_reg <= 1'b0;
    end

    // machine status: hardware beats software
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
            machine_status_reg <= MST_RST;
        else if (exc_enter)
        begin
            machine_status_reg[MB_XEN] <= 1'b0;
            machine_status_reg[MB_XPR] <= 1'b1;
            machine_status_reg[MB_USV] <= ms_q[MB_USR];
            machine_status_reg[MB_USR] <= 1'b0;
            machine_status_reg[MB_VSV] <= ms_q[MB_VRT];
            machine_status_reg[MB_VRT] <= 1'b0;
        end
        else if (brk_take)
            machine_status_reg[MB_BRK] <= 1'b1;
        else if (EXE.valid && EXE.ret_exc)
        begin
            machine_status_reg[MB_XEN] <= 1'b1;
            machine_status_reg[MB_XPR] <= 1'b0;
            machine_status_reg[MB_USR] <= ms_q[MB_USV];
            machine_status_reg[MB_VRT] <= ms_q[MB_VSV];
        end
        else if (EXE.valid && EXE.ret_brk)
        begin
            machine_status_reg[MB_BRK] <= 1'b0;
            machine_status_reg[MB_USR] <= ms_q[MB_USV];
            machine_status_reg[MB_VRT] <= ms_q[MB_VSV];
        end
        else if (wr_hit && WB_ADR_I == ADR_MST)
            machine_status_reg <= lane_merge(ms_q, WB_DAT_I, WB_SEL_I);
    end

    // cause record, fault address, slot target
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            exception_status_reg <= '0;
            fault_address_reg <= '0;
            branch_target_reg <= '0;
        end
        else if (exc_enter)
        begin
            exception_status_reg <= '0;
            exception_status_reg[4:0] <= CAUSE_CODE[sel_idx];
            exception_status_reg[5] <= ecc_cause; // detail: ecc source
            exception_status_reg[6] <= MEM.store; // detail: store access
            exception_status_reg[8:7] <= MEM.size; // detail: access size
            exception_status_reg[ES_DLY] <= EXE.in_delay;
            fault_address_reg <= data_cause ? MEM.addr : EXE.pc;
            if (EXE.in_delay)
                branch_target_reg <= EXE.branch_target;
        end
        else if (wr_hit)
        begin
            if (WB_ADR_I == ADR_CAU)
                exception_status_reg <= lane_merge(exception_status_reg, WB_DAT_I, WB_SEL_I);
            if (WB_ADR_I == ADR_FAD)
                fault_address_reg <= lane_merge(fault_address_reg, WB_DAT_I, WB_SEL_I);
            if (WB_ADR_I == ADR_BTG)
                branch_target_reg <= lane_merge(branch_target_reg, WB_DAT_I, WB_SEL_I);
        end
    end

    // sticky float flags, set beats clear
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
            float_status_reg <= '0;
        else
        begin
            logic [31:0] fs;
            fs = float_status_reg;
            if (wr_hit && WB_ADR_I == ADR_FLT)
                fs = lane_merge(fs, WB_DAT_I, WB_SEL_I);
            if (exc_enter && sel_idx == 4'(CI_FPU))
            begin
                fs[0] = fs[0] | UNIT.res_denorm; // underflow
                fs[1] = fs[1] | UNIT.res_nan; // overflow
                fs[2] = fs[2] | (UNIT.fdiv && UNIT.a_zero && !UNIT.b_inf);
                fs[3] = fs[3] | UNIT.bad_operand; // invalid operation
            end
            float_status_reg <= fs;
        end
    end

    // stack bounds, software written
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            stack_low_reg <= '0;
            stack_high_reg <= '1;
        end
        else if (wr_hit)
        begin
            if (WB_ADR_I == ADR_SLO)
                stack_low_reg <= lane_merge(stack_low_reg, WB_DAT_I, WB_SEL_I);
            if (WB_ADR_I == ADR_SHI)
                stack_high_reg <= lane_merge(stack_high_reg, WB_DAT_I, WB_SEL_I);
        end
    end

    // vector branch, flush, return write
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            VECTOR_TAKE <= 1'b0;
            VECTOR_PC <= '0;
            FLUSH <= 1'b0;
            KEEP_MEM <= 1'b0;
            RF_WE <= 1'b0;
            RF_ADDR <= '0;
            RF_DATA <= '0;
            RESV_CLEAR <= 1'b0;
        end
        else
        begin
            VECTOR_TAKE <= exc_enter || brk_take;
            FLUSH <= exc_enter;
            KEEP_MEM <= exc_enter && IMPRECISE && ecc_cause;
            RESV_CLEAR <= exc_enter || brk_take;
            RF_WE <= (exc_enter && r17_we) || brk_take;
            if (exc_enter)
            begin
                VECTOR_PC <= VEC_BASE + VEC_EXC;
                RF_ADDR <= RF_EXC;
                RF_DATA <= r17_val;
            end
            else if (brk_take)
            begin
                VECTOR_PC <= VEC_BASE + VEC_BRK;
                RF_ADDR <= RF_BRK;
                RF_DATA <= DEC_PC;
            end
        end
    end

    // debugger breakpoint pulse, break flag untouched
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
            SW_BREAK <= 1'b0;
        else
            SW_BREAK <= dbg_trap;
    end

    // one-cycle wishbone ack
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
            WB_ACK_O <= 1'b0;
        else
            WB_ACK_O <= WB_CYC_I && WB_STB_I && !WB_ACK_O;
    end

    // read data; unmapped reads return zero
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
            WB_DAT_O <= '0;
        else if (WB_CYC_I && WB_STB_I && !WB_ACK_O)
        begin
            case (WB_ADR_I)
                ADR_MST: WB_DAT_O <= machine_status_reg;
                ADR_CAU: WB_DAT_O <= exception_status_reg;
                ADR_FAD: WB_DAT_O <= fault_address_reg;
                ADR_FLT: WB_DAT_O <= float_status_reg;
                ADR_BTG: WB_DAT_O <= branch_target_reg;
                ADR_SLO: WB_DAT_O <= stack_low_reg;
                ADR_SHI: WB_DAT_O <= stack_high_reg;
                default: WB_DAT_O <= '0;
            endcase
        end
    end

endmodule

/* File: verif/ebu_core_properties.sv */
`timescale 1ns/1ps
module ebu_core_properties
    import ebu_pkg::*;
#(
    parameter logic [31:0] VEC_BASE = 32'h0000_0000
)(
    input logic MCLK,
    input logic RST_N,
    input logic WB_CYC_I,
    input logic WB_STB_I,
    input logic WB_ACK_O,
    input ebu_exe_t EXE,
    input ebu_mem_t MEM,
    input ebu_unit_t UNIT,
    input logic VECTOR_TAKE,
    input logic [31:0] VECTOR_PC,
    input logic FLUSH,
    input logic RF_WE,
    input logic [4:0] RF_ADDR,
    input logic [31:0] RF_DATA,
    input logic RESV_CLEAR,
    input logic SW_BREAK,
    input logic HALT_ERROR_OUT,
    input logic [31:0] STATUS
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    a_ack_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("register ack missing");
    a_unal_entry: assert property (MEM.valid && MEM.size == SZ_WORD && MEM.addr[1:0] != 2'h0
        && UNIT[3:0] == 4'h0 && !EXE.in_delay && !HALT_ERROR_OUT |=> VECTOR_TAKE && RF_WE
        && VECTOR_PC == VEC_BASE + VEC_EXC && RF_DATA == $past(EXE.pc) + PC_STEP)
        else $error("unaligned word entry wrong");
    a_div_entry: assert property (UNIT.div_valid && UNIT.divisor == 32'h0 && UNIT[3:0] == 4'h0
        && !HALT_ERROR_OUT |=> FLUSH && RF_ADDR == RF_EXC && STATUS[MB_XPR])
        else $error("divide by zero not trapped");
    a_entry_flags: assert property (FLUSH |-> STATUS[MB_XPR] && !STATUS[MB_XEN]
        && !STATUS[MB_USR] && !STATUS[MB_VRT] && RESV_CLEAR)
        else $error("entry status wrong");
    a_flush_vec: assert property (FLUSH |-> VECTOR_TAKE) else $error("flush without vector");
    a_brk_vector: assert property (VECTOR_TAKE && !FLUSH |-> VECTOR_PC == VEC_BASE + VEC_BRK
        && RF_ADDR == RF_BRK && STATUS[MB_BRK] && RESV_CLEAR)
        else $error("break entry wrong");
    a_brk_cause: assert property ($rose(STATUS[MB_BRK]) |-> VECTOR_TAKE && !FLUSH)
        else $error("break flag set without break");
    a_swbrk_cause: assert property (SW_BREAK |-> $past(EXE.trap_imm)
        && $past(EXE.trap_target) == VEC_BRK) else $error("stray debugger trap");
    a_halt_nested: assert property ($rose(HALT_ERROR_OUT) |-> $past(STATUS[MB_XPR])
        && !$past(STATUS[MB_XEN])) else $error("halt outside nested fault");
    a_halt_sticky: assert property (HALT_ERROR_OUT |=> HALT_ERROR_OUT && !VECTOR_TAKE)
        else $error("halt not sticky");
endmodule
bind ebu_core ebu_core_properties #(.VEC_BASE(VEC_BASE)) ebu_core_properties_i (.*);

/* File: verif/ebu_brk_src.sv */
`timescale 1ns/1ps
module ebu_brk_src (
    input logic clk,
    input logic rst_n,
    input logic m_req,
    input logic n_req,
    input logic taken,
    output logic m_brk,
    output logic n_brk
);
    logic done_reg; // maskable request already served
    logic n_req_reg; // last nonmaskable request
    // maskable held until taken, then dropped until renewed
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            m_brk <= 1'b0;
            done_reg <= 1'b0;
            n_req_reg <= 1'b0;
            n_brk <= 1'b0;
        end
        else
        begin
            done_reg <= m_req && (done_reg || (m_brk && taken));
            m_brk <= m_req && !done_reg && !(m_brk && taken);
            n_req_reg <= n_req;
            n_brk <= n_req && !n_req_reg;
        end
    end
endmodule

/* File: verif/ebu_core_tb.sv */
`timescale 1ns/1ps
module ebu_core_tb;
    import ebu_pkg::*;
    localparam logic [31:0] VB = 32'h0000_1000; // vector base
    localparam logic [31:0] SLO = 32'h0000_0100; // stack low bound
    localparam logic [31:0] SHI = 32'h0000_8000; // stack high bound
    logic MCLK = 1'b0, RST_N = 1'b0, cyc = 1'b0, we = 1'b0, mreq = 1'b0, nreq = 1'b0;
    logic [3:0] sel = 4'hf;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, dpc = 32'h0, rdat, dato, vpc, rfd, stat;
    ebu_exe_t exe = '0;
    ebu_mem_t mem = '0;
    ebu_rsp_t rsp = '0;
    ebu_unit_t unit = '0;
    logic mbrk, nbrk, ack, vt, swb;
    logic [4:0] rfa;
    int num_errors = 0, n_checks = 0, seed = 32'h8fcf;
    initial
    begin
        forever #2 MCLK = ~MCLK;
    end
    ebu_core #(.VEC_BASE(VB)) ebu_core_i (.MCLK(MCLK), .RST_N(RST_N), .WB_CYC_I(cyc),
        .WB_STB_I(cyc), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
        .WB_DAT_O(dato), .WB_ACK_O(ack), .EXE(exe), .MEM(mem), .RSP(rsp), .UNIT(unit),
        .DEC_PC(dpc), .MASKABLE_BREAK_IN(mbrk), .NONMASKABLE_BREAK_IN(nbrk), .VECTOR_TAKE(vt),
        .VECTOR_PC(vpc), .FLUSH(), .KEEP_MEM(), .RF_WE(), .RF_ADDR(rfa), .RF_DATA(rfd),
        .RESV_CLEAR(), .SW_BREAK(swb), .HALT_ERROR_OUT(), .STATUS(stat));
    ebu_brk_src ebu_brk_src_i (.clk(MCLK), .rst_n(RST_N), .m_req(mreq), .n_req(nreq),
        .taken(vt), .m_brk(mbrk), .n_brk(nbrk));
    // verdict and end of run
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // compare one value
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one wishbone cycle plus an idle cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge MCLK);
        while (ack !== 1'b1 && k < 20)
        begin
            @(posedge MCLK);
            k++;
        end
        rdat = dato;
        cyc <= 1'b0;
        @(posedge MCLK);
        if (k == 20)
        begin
            num_errors++;
            conclude();
        end
    endtask
    // expected cause code, 1f if none
    function automatic logic [4:0] model(input ebu_mem_t m, input ebu_unit_t u);
        if (m.base_r1 && (m.addr < SLO || m.addr > SHI)) return 5'h07;
        if ((m.size == SZ_WORD && m.addr[1:0] != 2'h0) || (m.size == SZ_HALF && m.addr[0]))
            return 5'h01;
        if (u.div_valid && (u.divisor == 32'h0 || (u.div_signed && u.dividend == DIV_MOST_NEG
            && u.divisor == DIV_MINUS_ONE))) return 5'h05;
        return 5'h1f;
    endfunction
    // one cause edge, answer check, handler return
    task automatic fire(input logic [4:0] ec, input logic [31:0] pc);
        @(posedge MCLK);
        exe <= '0;
        mem <= '0;
        unit <= '0;
        @(posedge MCLK);
        chk(32'(vt), 32'(ec != 5'h1f));
        if (ec != 5'h1f)
        begin
            chk(vpc, VB + VEC_EXC);
            chk(rfd, pc + PC_STEP);
            chk(stat, 32'h0000_5200);
            wb(1'b0, ADR_CAU, 32'h0);
            chk(32'(rdat[4:0]), 32'(ec));
            exe.valid <= 1'b1;
            exe.ret_exc <= 1'b1;
            @(posedge MCLK);
            exe <= '0;
            repeat (2) @(posedge MCLK);
            chk(stat, 32'h0000_7900);
        end
    endtask
    // watch eight cycles for a break
    task automatic see(input logic e);
        logic s;
        s = 1'b0;
        repeat (8)
        begin
            @(posedge MCLK);
            if (vt === 1'b1 && !s)
            begin
                s = 1'b1;
                chk(vpc, VB + VEC_BRK);
                chk(rfd, dpc);
                chk(32'(stat[MB_BRK]), 32'h1);
            end
        end
        chk(32'(s), 32'(e));
    endtask
    initial
    begin
        ebu_mem_t m;
        ebu_unit_t u;
        logic [31:0] p;
        repeat (12) @(posedge MCLK);
        RST_N <= 1'b1;
        @(posedge MCLK);
        wb(1'b0, ADR_MST, 32'h0);
        chk(rdat, MST_RST);
        wb(1'b0, ADR_SHI, 32'h0);
        chk(rdat, 32'hffff_ffff);
        wb(1'b0, 8'h1c, 32'h0);
        chk(rdat, 32'h0);
        wb(1'b1, ADR_SLO, SLO);
        wb(1'b1, ADR_SHI, SHI);
        wb(1'b1, ADR_MST, 32'h0000_2900);
        wb(1'b0, ADR_MST, 32'h0);
        chk(rdat, 32'h0000_2900);
        $display("test registers done");
        repeat (40)
        begin
            m = '0;
            u = '0;
            m.valid = 1'b1;
            m.size = 2'($random(seed));
            if (m.size == SZ_LONG) m.size = SZ_BYTE;
            m.addr = $random(seed) & 32'h0000_ffff;
            m.base_r1 = ($random(seed) & 3) == 0;
            u.div_valid = 1'($random(seed));
            u.div_signed = 1'($random(seed));
            u.dividend = ($random(seed) & 1) ? DIV_MOST_NEG : $random(seed);
            u.divisor = ($random(seed) & 1) ? 32'h0 : ($random(seed) & 1) ? DIV_MINUS_ONE : 32'h7;
            p = $random(seed) & 32'hffff_fffc;
            mem <= m;
            unit <= u;
            exe.valid <= 1'b1;
            exe.pc <= p;
            fire(model(m, u), p);
        end
        $display("test causes done");
        dpc <= $random(seed);
        mreq <= 1'b1;
        see(1'b1);
        mreq <= 1'b0;
        @(posedge MCLK);
        mreq <= 1'b1;
        see(1'b0);
        mreq <= 1'b0;
        nreq <= 1'b1;
        see(1'b1);
        nreq <= 1'b0;
        exe.valid <= 1'b1;
        exe.ret_brk <= 1'b1;
        @(posedge MCLK);
        exe.ret_brk <= 1'b0;
        exe.trap_imm <= 1'b1;
        exe.trap_target <= VEC_BRK;
        @(posedge MCLK);
        exe <= '0;
        chk(32'(stat[MB_BRK]), 32'h0);
        @(posedge MCLK);
        chk(32'(swb), 32'h1);
        chk(32'(stat[MB_BRK]), 32'h0);
        $display("test breaks done");
        conclude();
    end
endmodule
